// *** hw/ars_defines.svh ***
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

// ----------------------------------------------------------------
// clock and tick
// ----------------------------------------------------------------
`define ARS_CLK_PERIOD_NS 10
`define ARS_TICK_MS 10
`define ARS_TICK_CYCLES (`ARS_TICK_MS * 1000000 / `ARS_CLK_PERIOD_NS)
`define ARS_TIME_W 20
`define ARS_MS_TO_TICKS(ms) 20'((ms) / `ARS_TICK_MS)

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ARS_ADDR_W 8
`define ARS_ADDR_CTRL 8'h00
`define ARS_ADDR_STATUS 8'h38
`define ARS_NUM_TIMES 13
`define ARS_CTRL_RST 10'h013

// ----------------------------------------------------------------
// timing register indices (byte address = 4 * (index + 1))
// ----------------------------------------------------------------
`define ARS_T_RECLAIM 0
`define ARS_T_SYNC_WAIT 1
`define ARS_T_SYNC_SW 2
`define ARS_T_DYN_BLOCK 3
`define ARS_T_MAN_HOLD 4
`define ARS_T_ACTION 5
`define ARS_T_START_MAX 6
`define ARS_T_DEAD_DELAY 7
`define ARS_T_CB_SUP 8
`define ARS_T_CLOSE_PULSE 9
`define ARS_T_DEAD_PH 10
`define ARS_T_DEAD_EF 11
`define ARS_T_BRK_CLOSE 12

// ----------------------------------------------------------------
// timing reset values in milliseconds
// ----------------------------------------------------------------
`define ARS_RECLAIM_MS 2000
`define ARS_SYNC_WAIT_MS 10000
`define ARS_SYNC_SW_MS 10000
`define ARS_DYN_BLOCK_MS 1500
`define ARS_MAN_HOLD_MS 1000
`define ARS_ACTION_MS 1000
`define ARS_START_MAX_MS 1000
`define ARS_DEAD_DELAY_MS 3000
`define ARS_CB_SUP_MS 1000
`define ARS_CLOSE_PULSE_MS 100
`define ARS_DEAD_PH_MS 500
`define ARS_DEAD_EF_MS 1000
`define ARS_BRK_CLOSE_MS 50

`endif

// *** hw/ars_pkg.sv ***
`include "ars_defines.svh"

package ars_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    ARS_NOT_READY = 11'h001,
    ARS_IDLE = 11'h002,
    ARS_ACTION = 11'h004,
    ARS_TRIP_WAIT = 11'h008,
    ARS_DEAD = 11'h010,
    ARS_CB_WAIT = 11'h020,
    ARS_SYNC_WAIT = 11'h040,
    ARS_SYNC_SW = 11'h080,
    ARS_CLOSING = 11'h100,
    ARS_RECLAIM = 11'h200,
    ARS_DYN_BLOCK = 11'h400
  } ars_state_e;

  typedef logic [`ARS_TIME_W-1:0] ars_time_t;

  // field pins, synchronised before use
  typedef struct packed {
    logic pickup;
    logic trip;
    logic sync_release;
    logic breaker_ready;
    logic breaker_open_position;
    logic breaker_open_single_pole;
    logic reclose_start;
    logic manual_close;
    logic general_block;
    logic earth_fault;
    logic dead_time_delay;
    logic evolving_fault;
  } ars_pins_s;

  // control register, bit 0 is op_en
  typedef struct packed {
    logic breaker_state_check_enable;
    logic evolve_3ph;
    logic dead_time_trigger_select;
    logic [2:0] phase_fault_cycle_count;
    logic [2:0] earth_fault_cycle_count;
    logic op_en;
  } ars_ctrl_s;

  typedef struct packed {
    logic close_cmd;
    logic sync_switch_close_request;
    logic definitive_trip;
    logic blocked;
    logic not_ready;
    logic dyn_blocked;
    logic in_progress;
  } ars_out_s;

  typedef struct packed {
    ars_state_e state;
    ars_time_t tmr;
    ars_time_t tmr2;
    ars_time_t man_hold;
    logic [19:0] tick_cnt;
    logic [2:0] cycle;
    logic earth;
    logic pick_seen;
    logic man_prev;
    logic open_prev;
    ars_pins_s s1;
    ars_pins_s s2;
    ars_ctrl_s ctrl;
    logic [`ARS_NUM_TIMES-1:0][`ARS_TIME_W-1:0] times;
    ars_out_s out;
    logic [31:0] rdata;
  } ars_regs_s;

endpackage

// *** hw/ars_top.sv ***
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ars_defines.svh"

module ars_top
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = `ARS_TICK_CYCLES
) (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic [`ARS_ADDR_W-1:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after strobe
  input wire ars_pins_s i_pins, // field inputs, asynchronous
  input wire logic i_coincide_valid, // slip prediction valid
  input wire ars_time_t i_coincide_ticks, // ticks to vector coincidence
  output logic o_close_cmd, // breaker close command
  output logic o_sync_switch_close_request, // sync switching active
  output logic o_definitive_trip, // final trip pulse
  output logic o_blocked, // blocked status
  output logic o_not_ready, // not-ready state
  output logic o_dyn_blocked, // dynamic blocked state
  output logic o_in_progress, // reclosing cycle running
  output logic [2:0] o_cycle // reclose shots issued
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ars_regs_s r;
  ars_regs_s next_r;
  ars_pins_s p;
  logic tick;
  logic man_edge;
  logic open_edge;
  logic running;
  logic nr_cond;
  logic dyn_req;
  logic final_trip;
  logic [2:0] lim;

  function automatic ars_time_t dec(input ars_time_t v, input logic t);
    dec = (t && v != '0) ? v - 20'h00001 : v;
  endfunction

  function automatic logic [2:0] clamp4(input logic [2:0] v);
    clamp4 = (v > 3'h4) ? 3'h4 : v;
  endfunction

  function automatic logic is_run(input ars_state_e s);
    is_run = !(s inside {ARS_IDLE, ARS_NOT_READY, ARS_DYN_BLOCK});
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    p = r.s2;
    // two-stage input synchroniser
    next_r.s1 = i_pins;
    next_r.s2 = r.s1;
    // periodic tick for every timer
    tick = (r.tick_cnt == 20'(TICK_CYCLES - 1));
    next_r.tick_cnt = tick ? 20'h00000 : r.tick_cnt + 20'h00001;
    next_r.tmr = dec(r.tmr, tick);
    next_r.tmr2 = dec(r.tmr2, tick);
    next_r.man_hold = dec(r.man_hold, tick);
    man_edge = p.manual_close && !r.man_prev;
    open_edge = p.breaker_open_single_pole && !r.open_prev;
    next_r.man_prev = p.manual_close;
    next_r.open_prev = p.breaker_open_single_pole;
    if (man_edge) begin
      next_r.man_hold = r.times[`ARS_T_MAN_HOLD];
    end
    running = is_run(r.state);
    lim = r.earth ? clamp4(r.ctrl.earth_fault_cycle_count)
                  : clamp4(r.ctrl.phase_fault_cycle_count);
    nr_cond = !r.ctrl.op_en || !p.breaker_ready || man_edge ||
              r.man_hold != '0 || p.general_block ||
              (p.breaker_open_position &&
               (r.ctrl.breaker_state_check_enable ||
                r.ctrl.dead_time_trigger_select));
    dyn_req = 1'b0;
    final_trip = 1'b0;
    next_r.out.definitive_trip = 1'b0;

    // sequencer
    unique case (r.state)
      ARS_NOT_READY: begin
        if (!nr_cond) begin
          next_r.state = ARS_IDLE;
        end
      end
      ARS_IDLE: begin
        if (nr_cond) begin
          next_r.state = ARS_NOT_READY;
        end else if (p.pickup || p.trip) begin
          next_r.state = ARS_ACTION;
          next_r.tmr = r.times[`ARS_T_ACTION];
          next_r.cycle = 3'h0;
        end
      end
      ARS_ACTION: begin
        if (p.trip) begin
          next_r.state = ARS_TRIP_WAIT;
          next_r.tmr = r.times[`ARS_T_START_MAX];
          if (r.cycle == 3'h0) begin
            next_r.earth = p.earth_fault;
          end
        end else if (r.tmr == '0) begin
          dyn_req = 1'b1;
        end else if (!p.pickup) begin
          next_r.state = ARS_IDLE;
          next_r.cycle = 3'h0;
        end
      end
      ARS_TRIP_WAIT: begin
        if (r.cycle >= lim) begin
          final_trip = 1'b1;
        end else if (r.ctrl.dead_time_trigger_select ? p.breaker_open_position
                                                     : !p.trip) begin
          next_r.state = ARS_DEAD;
          next_r.tmr = r.earth ? r.times[`ARS_T_DEAD_EF] : r.times[`ARS_T_DEAD_PH];
          next_r.tmr2 = r.times[`ARS_T_DEAD_DELAY];
        end else if (r.tmr == '0) begin
          dyn_req = 1'b1;
        end
      end
      ARS_DEAD: begin
        next_r.tmr2 = r.tmr2;
        if (p.trip) begin
          if (!r.earth) begin
            final_trip = 1'b1;
          end else begin
            next_r.state = ARS_TRIP_WAIT;
            next_r.tmr = r.times[`ARS_T_START_MAX];
          end
        end else if (p.evolving_fault && r.earth) begin
          if (!r.ctrl.evolve_3ph) begin
            final_trip = 1'b1;
          end else begin
            next_r.earth = 1'b0;
            next_r.tmr = r.times[`ARS_T_DEAD_PH];
          end
        end else if (p.dead_time_delay) begin
          // dead time held while delayed, delay limited
          next_r.tmr = r.tmr;
          next_r.tmr2 = dec(r.tmr2, tick);
          if (r.tmr2 == '0) begin
            dyn_req = 1'b1;
          end
        end else if (r.tmr == '0) begin
          next_r.state = ARS_CB_WAIT;
          next_r.tmr = r.times[`ARS_T_CB_SUP];
        end
      end
      ARS_CB_WAIT: begin
        if (p.breaker_ready) begin
          next_r.state = ARS_SYNC_WAIT;
          next_r.tmr = r.times[`ARS_T_SYNC_WAIT];
        end else if (r.tmr == '0) begin
          dyn_req = 1'b1;
        end
      end
      ARS_SYNC_WAIT: begin
        if (p.sync_release) begin
          next_r.state = ARS_CLOSING;
        end else if (r.tmr == '0) begin
          next_r.state = ARS_SYNC_SW;
          next_r.tmr = r.times[`ARS_T_SYNC_SW];
        end
      end
      ARS_SYNC_SW: begin
        if (i_coincide_valid && i_coincide_ticks == r.times[`ARS_T_BRK_CLOSE]) begin
          next_r.state = ARS_CLOSING;
        end else if (r.tmr == '0) begin
          dyn_req = 1'b1;
        end
      end
      ARS_CLOSING: begin
        if (p.pickup) begin
          next_r.pick_seen = 1'b1;
        end
        if (p.trip) begin
          next_r.state = ARS_TRIP_WAIT;
          next_r.tmr = r.times[`ARS_T_START_MAX];
        end else if (r.tmr2 == '0) begin
          next_r.state = ARS_RECLAIM;
        end
      end
      ARS_RECLAIM: begin
        if (p.pickup) begin
          next_r.pick_seen = 1'b1;
        end
        if (p.trip) begin
          next_r.state = ARS_TRIP_WAIT;
          next_r.tmr = r.times[`ARS_T_START_MAX];
        end else if (r.tmr == '0) begin
          if (r.pick_seen || p.pickup) begin
            next_r.state = ARS_ACTION;
            next_r.tmr = r.times[`ARS_T_ACTION];
          end else begin
            next_r.state = ARS_IDLE;
            next_r.cycle = 3'h0;
          end
        end
      end
      ARS_DYN_BLOCK: begin
        if (r.tmr == '0) begin
          next_r.state = ARS_IDLE;
          next_r.cycle = 3'h0;
        end
      end
    endcase

    // close issue starts reclaim and pulse timers
    if (next_r.state == ARS_CLOSING && r.state != ARS_CLOSING) begin
      next_r.tmr = r.times[`ARS_T_RECLAIM];
      next_r.tmr2 = r.times[`ARS_T_CLOSE_PULSE];
      next_r.cycle = r.cycle + 3'h1;
      next_r.pick_seen = 1'b0;
    end
    if (final_trip) begin
      next_r.out.definitive_trip = 1'b1;
      dyn_req = 1'b1;
    end
    if (running && (man_edge || p.general_block ||
                    (open_edge && !p.reclose_start))) begin
      dyn_req = 1'b1;
    end
    if (dyn_req) begin
      next_r.state = ARS_DYN_BLOCK;
      next_r.tmr = r.times[`ARS_T_DYN_BLOCK];
      next_r.cycle = 3'h0;
    end

    // registered outputs follow the next state
    next_r.out.close_cmd = (next_r.state == ARS_CLOSING);
    next_r.out.sync_switch_close_request = (next_r.state == ARS_SYNC_SW);
    next_r.out.not_ready = (next_r.state == ARS_NOT_READY);
    next_r.out.dyn_blocked = (next_r.state == ARS_DYN_BLOCK);
    next_r.out.blocked = next_r.out.not_ready || next_r.out.dyn_blocked;
    next_r.out.in_progress = is_run(next_r.state);

    // register writes
    if (i_wr) begin
      if (i_addr == `ARS_ADDR_CTRL) begin
        next_r.ctrl = i_wdata[9:0];
      end
      for (int k = 0; k < `ARS_NUM_TIMES; k++) begin
        if (i_addr == 8'(4 * (k + 1))) begin
          next_r.times[k] = i_wdata[`ARS_TIME_W-1:0];
        end
      end
    end

    // register reads, data in the following cycle only
    next_r.rdata = 32'h00000000;
    if (i_rd) begin
      if (i_addr == `ARS_ADDR_CTRL) begin
        next_r.rdata = {22'h000000, r.ctrl};
      end else if (i_addr == `ARS_ADDR_STATUS) begin
        next_r.rdata = {10'h000, r.out, r.earth, r.cycle, r.state};
      end
      for (int k = 0; k < `ARS_NUM_TIMES; k++) begin
        if (i_addr == 8'(4 * (k + 1))) begin
          next_r.rdata = {12'h000, r.times[k]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
      r.state <= ARS_NOT_READY;
      r.out.not_ready <= 1'b1;
      r.out.blocked <= 1'b1;
      r.ctrl <= `ARS_CTRL_RST;
      r.times <= {`ARS_MS_TO_TICKS(`ARS_BRK_CLOSE_MS), `ARS_MS_TO_TICKS(`ARS_DEAD_EF_MS),
                  `ARS_MS_TO_TICKS(`ARS_DEAD_PH_MS), `ARS_MS_TO_TICKS(`ARS_CLOSE_PULSE_MS),
                  `ARS_MS_TO_TICKS(`ARS_CB_SUP_MS), `ARS_MS_TO_TICKS(`ARS_DEAD_DELAY_MS),
                  `ARS_MS_TO_TICKS(`ARS_START_MAX_MS), `ARS_MS_TO_TICKS(`ARS_ACTION_MS),
                  `ARS_MS_TO_TICKS(`ARS_MAN_HOLD_MS), `ARS_MS_TO_TICKS(`ARS_DYN_BLOCK_MS),
                  `ARS_MS_TO_TICKS(`ARS_SYNC_SW_MS), `ARS_MS_TO_TICKS(`ARS_SYNC_WAIT_MS),
                  `ARS_MS_TO_TICKS(`ARS_RECLAIM_MS)};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign o_rdata = r.rdata;
  assign o_close_cmd = r.out.close_cmd;
  assign o_sync_switch_close_request = r.out.sync_switch_close_request;
  assign o_definitive_trip = r.out.definitive_trip;
  assign o_blocked = r.out.blocked;
  assign o_not_ready = r.out.not_ready;
  assign o_dyn_blocked = r.out.dyn_blocked;
  assign o_in_progress = r.out.in_progress;
  assign o_cycle = r.cycle;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_close_permit;
    $rose(o_close_cmd) |->
      ($past(r.state) == ARS_SYNC_WAIT && $past(p.sync_release)) ||
      ($past(r.state) == ARS_SYNC_SW && $past(i_coincide_valid));
  endproperty
  a_close_permit: assert property (p_close_permit)
    else $error("close issued without permit");

  property p_ssr_enter;
    (r.state == ARS_SYNC_WAIT && r.tmr == '0 && !p.sync_release && !dyn_req)
      |=> o_sync_switch_close_request && r.state == ARS_SYNC_SW;
  endproperty
  a_ssr_enter: assert property (p_ssr_enter)
    else $error("sync switching not started on permit timeout");

  property p_sw_timeout;
    (r.state == ARS_SYNC_SW && r.tmr == '0 && !next_r.out.close_cmd)
      |=> o_dyn_blocked && !o_sync_switch_close_request;
  endproperty
  a_sw_timeout: assert property (p_sw_timeout)
    else $error("sync-switch timeout did not block");

  property p_close_start;
    $rose(o_close_cmd) |-> r.tmr == $past(r.times[`ARS_T_RECLAIM]) &&
      r.tmr2 == $past(r.times[`ARS_T_CLOSE_PULSE]);
  endproperty
  a_close_start: assert property (p_close_start)
    else $error("reclaim or pulse timer not loaded at close");

  property p_man_close_run;
    (running && man_edge) |=> o_dyn_blocked ##1 o_dyn_blocked;
  endproperty
  a_man_close_run: assert property (p_man_close_run)
    else $error("manual close while running did not block");

  property p_idle_man;
    (r.state == ARS_IDLE && man_edge) |=> o_not_ready && o_blocked;
  endproperty
  a_idle_man: assert property (p_idle_man)
    else $error("manual close while idle not not-ready");

  property p_final_trip;
    o_definitive_trip |-> o_dyn_blocked ##1 !o_definitive_trip;
  endproperty
  a_final_trip: assert property (p_final_trip)
    else $error("definitive trip not followed by blocking");

  property p_no_close_blocked;
    o_dyn_blocked |=> !$rose(o_close_cmd);
  endproperty
  a_no_close_blocked: assert property (p_no_close_blocked)
    else $error("close issued while dynamically blocked");

  property p_blocked_out;
    (o_dyn_blocked || o_not_ready) |-> o_blocked && !o_in_progress;
  endproperty
  a_blocked_out: assert property (p_blocked_out)
    else $error("blocked status wrong");

  property p_trip_cuts;
    (o_close_cmd && p.trip && !dyn_req) |=> !o_close_cmd;
  endproperty
  a_trip_cuts: assert property (p_trip_cuts)
    else $error("close pulse not cut by trip");

endmodule // ars_top

`default_nettype wire

// *** tb/ars_breaker_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ars_breaker_model (
  input wire logic i_clk, // bench clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_close_cmd, // automatic or manual close command
  input wire logic i_open_req, // protection trip or manual open
  input wire logic i_unready, // operating mechanism not charged
  output logic o_ready, // ready for a close operation
  output logic o_open // auxiliary contact, open position
);
  // contacts open on any open request and close on the command
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_open <= 1'b0;
    end else if (i_open_req) begin
      o_open <= 1'b1;
    end else if (i_close_cmd) begin
      o_open <= 1'b0;
    end
  end
  // ready only while the mechanism is charged
  assign o_ready = !i_unready;
endmodule // ars_breaker_model
`default_nettype wire

// *** tb/ars_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module ars_top_bench import ars_pkg::*;;
  logic i_clk, i_arst_n, i_wr, i_rd, i_coincide_valid, man_open, brk_unready, brk_ready, brk_open;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  ars_time_t i_coincide_ticks;
  ars_pins_s pv, pins;
  logic [6:0] outs;
  logic [2:0] o_cycle;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$], msk_q[$];
  logic [16:0] lf;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_def = 0;
  int tv[13] = '{8, 60, 30, 5, 5, 10, 30, 30, 5, 2, 3, 3, 2};

  ars_top #(.TICK_CYCLES(4)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pins(pins),
    .i_coincide_valid(i_coincide_valid), .i_coincide_ticks(i_coincide_ticks),
    .o_close_cmd(outs[6]), .o_sync_switch_close_request(outs[5]),
    .o_definitive_trip(outs[4]), .o_blocked(outs[3]), .o_not_ready(outs[2]),
    .o_dyn_blocked(outs[1]), .o_in_progress(outs[0]), .o_cycle(o_cycle));
  ars_breaker_model BRK (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_close_cmd(outs[6] | pv.manual_close),
    .i_open_req(pv.trip | man_open), .i_unready(brk_unready), .o_ready(brk_ready),
    .o_open(brk_open));

  // breaker contacts feed the field inputs
  always_comb begin
    pins = pv;
    pins.breaker_ready = brk_ready;
    pins.breaker_open_position = brk_open;
  end
  // free-running clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // read results against the oldest note, count final trips
  always @(posedge i_clk) begin
    if (rd_d) chk(exp_q.pop_front(), o_rdata & msk_q.pop_front());
    if (outs[4] === 1'b1) n_def++;
    rd_d <= i_rd;
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge i_clk);
    n_mismatch++;
    end_of_test();
  end

  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task end_of_test();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wt(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[b] !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    if (outs[b] !== v) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, v, outs[b]);
      end_of_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task hit(input logic v);
    pv.pickup <= v;
    pv.trip <= v;
    pv.reclose_start <= v;
  endtask
  task fault();
    hit(1'b1);
    repeat (8) @(posedge i_clk);
    hit(1'b0);
  endtask

  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    pv = '0;
    i_coincide_valid = 1'b0;
    i_coincide_ticks = '0;
    man_open = 1'b0;
    brk_unready = 1'b0;
    lf = 17'h103b0;
    repeat (5) @(posedge i_clk);
    chk(32'h0c, outs);
    i_arst_n <= 1'b1;
    wt(2, 1'b0, 20);
    rd(8'h00, 32'h013, 32'h3ff);
    rd(8'h38, 32'h002, 32'h7ff);
    rd(8'h3c, 32'h0, 32'hffffffff);
    for (int i = 0; i < 13; i++) wr(8'(4 * i + 4), 32'(tv[i]));
    for (int i = 0; i < 13; i++) rd(8'(4 * i + 4), 32'(tv[i]), 32'hfffff);
    // reclose held until the permit, then reclaim success
    fault();
    repeat (150) @(posedge i_clk);
    rd(8'h38, 32'h040, 32'h7ff);
    pv.sync_release <= 1'b1;
    wt(6, 1'b1, 10);
    chk(32'h1, o_cycle);
    wt(6, 1'b0, 20);
    pv.sync_release <= 1'b0;
    repeat (16) @(posedge i_clk);
    rd(8'h38, 32'h200, 32'h7ff);
    wt(0, 1'b0, 60);
    rd(8'h38, 32'h002, 32'h3fff);
    // refault in reclaim after the last cycle
    pv.sync_release <= 1'b1;
    fault();
    wt(6, 1'b1, 100);
    wt(6, 1'b0, 20);
    hit(1'b1);
    wt(4, 1'b1, 20);
    rd(8'h38, 32'h50400, 32'h507ff);
    hit(1'b0);
    chk(32'h0, outs[6]);
    wt(1, 1'b0, 40);
    // synchronous switching at vector coincidence
    pv.sync_release <= 1'b0;
    wr(8'h08, 32'h6);
    fault();
    wt(5, 1'b1, 80);
    i_coincide_valid <= 1'b1;
    repeat (16) begin
      lf = lfsr(lf);
      i_coincide_ticks <= {3'h0, lf} | 20'h00100;
      @(posedge i_clk);
      chk(32'h0, outs[6]);
    end
    i_coincide_ticks <= 20'h00002;
    wt(6, 1'b1, 8);
    i_coincide_valid <= 1'b0;
    wt(0, 1'b0, 80);
    // synchronous switching runs out
    wr(8'h0c, 32'h4);
    fault();
    wt(5, 1'b1, 80);
    wt(1, 1'b1, 30);
    rd(8'h38, 32'h10000, 32'h310000);
    wt(1, 1'b0, 40);
    // phase refault inside the dead time
    fault();
    repeat (2) @(posedge i_clk);
    hit(1'b1);
    wt(4, 1'b1, 20);
    hit(1'b0);
    wt(1, 1'b0, 40);
    // evolving earth fault under the blocking policy
    pv.earth_fault <= 1'b1;
    fault();
    repeat (2) @(posedge i_clk);
    pv.evolving_fault <= 1'b1;
    wt(4, 1'b1, 20);
    wt(1, 1'b0, 40);
    // evolving earth fault under the three-phase policy recloses
    wr(8'h00, 32'h113);
    pv.sync_release <= 1'b1;
    fault();
    wt(6, 1'b1, 80);
    wt(0, 1'b0, 80);
    pv.sync_release <= 1'b0;
    pv.earth_fault <= 1'b0;
    pv.evolving_fault <= 1'b0;
    wr(8'h00, 32'h013);
    // manual close while running, then while idle
    fault();
    wt(0, 1'b1, 20);
    pv.manual_close <= 1'b1;
    wt(1, 1'b1, 10);
    pv.manual_close <= 1'b0;
    wt(1, 1'b0, 40);
    wt(2, 1'b0, 40);
    pv.manual_close <= 1'b1;
    wt(2, 1'b1, 10);
    rd(8'h38, 32'h001, 32'h7ff);
    pv.manual_close <= 1'b0;
    wt(2, 1'b0, 40);
    // pickup with no trip in the action time
    pv.pickup <= 1'b1;
    wt(1, 1'b1, 70);
    pv.pickup <= 1'b0;
    wt(3, 1'b0, 60);
    // idle blocking conditions
    brk_unready <= 1'b1;
    wt(2, 1'b1, 10);
    brk_unready <= 1'b0;
    wt(2, 1'b0, 10);
    pv.general_block <= 1'b1;
    wt(2, 1'b1, 10);
    pv.general_block <= 1'b0;
    wt(2, 1'b0, 10);
    wr(8'h00, 32'h012);
    wt(2, 1'b1, 10);
    wr(8'h00, 32'h213);
    wt(2, 1'b0, 10);
    man_open <= 1'b1;
    wt(2, 1'b1, 10);
    chk(32'h3, n_def);
    end_of_test();
  end
endmodule // ars_top_bench
`default_nettype wire
